// *** design/ms_tick_divider.sv ***
// Divider that turns the reference clock into a one-cycle millisecond enable.
`timescale 1ns/10ps
module ms_tick_divider #(
    parameter int DIVIDE = 100000
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    output logic      tick
);
    logic [31:0] count_reg;
    wire         wrap = (count_reg == 32'(DIVIDE - 1));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 32'h0;
        end else begin
            count_reg <= wrap ? 32'h0 : count_reg + 32'h1;
        end
    end

    assign tick = wrap;

    chk_tick_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick |=> !tick or (DIVIDE == 1))
        else $error("tick lasted more than one cycle");
endmodule

// *** design/supervisor_pkg.sv ***
// Register map, field positions, reset values and timing constants of the supervisor block.
package supervisor_pkg;
    localparam int          CLK_HZ              = 100_000_000;
    localparam logic [7:0]  SUPERVISOR_SETTING_ADDR = 8'h2D;
    localparam logic [7:0]  FAULT_FLAGS_ADDR    = 8'h2E;
    localparam logic [7:0]  POWER_GOOD_STATE_ADDR = 8'h2F;
    localparam int          BUCK_RST_BIT        = 7;
    localparam int          BUCKBOOST_RST_BIT   = 6;
    localparam int          RESET_TIME_BIT      = 5;
    localparam int          WDOG_PERIOD_LSB     = 3;
    localparam int          WDOG_ENABLE_BIT     = 2;
    localparam int          SHIP_ENABLE_BIT     = 1;
    localparam int          WDOG_SERVICE_BIT    = 0;
    localparam logic [7:0]  SETTING_RESET       = 8'h80;
    localparam logic [7:0]  SETTING_WRITE_MASK  = 8'hFE;
    localparam int          FAULT_BATT_UNDERVOLT_FAULT_BIT    = 7;
    localparam int          FAULT_WDOG_BIT      = 2;
    localparam int          FAULT_THERMAL_BIT   = 0;
    localparam logic [7:0]  FAULT_IMPL_MASK     = 8'hF5;
    localparam logic [7:0]  FAULT_RESET         = 8'h00;
    // Times in milliseconds, as printed; tick is one millisecond.
    localparam int          TICK_MS             = 1;
    localparam int          TICK_CYCLES         = CLK_HZ / 1000 * TICK_MS;
    localparam int          RESET_SHORT_MS      = 200;
    localparam int          RESET_LONG_MS       = 1600;
    localparam int          WDOG_P0_MS          = 12500;
    localparam int          WDOG_P1_MS          = 25600;
    localparam int          WDOG_P2_MS          = 50000;
    localparam int          WDOG_P3_MS          = 100000;
    localparam int          SHIP_PRESS_MS       = 12000;
    localparam int          DEGLITCH_MS         = 50;
endpackage

// *** design/supervisor_watchdog_fault_status.sv ***
// Supervisor, watchdog, shipment entry and fault/status registers of the power chip.
// Summary of operation
// - Bit 7 lets buck monitor drive reset.
// - Bit 6 lets buck-boost monitor drive reset.
// - Reset hold 200 ms or 1.6 s.
// - Bits 4:3 pick watchdog period.
// - Watchdog runs only when enabled, default off.
// - Long 12 s press enters shipment if enabled.
// - Service bit restarts watchdog, self-clears.
// - Faults stick until write-one or supply cycle.
// - Fault bits 7:4 latch battery protection events.
// - Fault bit 2 flags watchdog expiry.
// - Fault bit 0 flags thermal shutdown.
// - Status bit 5 shows deglitched press.
// - Status bit 4 shows charge complete.
// - Status bit 3 shows supply in range.
// - Status bit 2 shows battery above weak.
// - Status bit 1 shows buck-boost good.
// - Status bit 0 shows buck good.
`timescale 1ns/10ps
module supervisor_watchdog_fault_status
    import supervisor_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       manual_reset_input_n,
    input  wire logic       bus_supply_input,
    input  wire logic       supply_in_range_status,
    input  wire logic       charge_done_status,
    input  wire logic       battery_above_weak_status,
    input  wire logic       buckboost_good_status,
    input  wire logic       buck_good_status,
    input  wire logic       batt_undervolt_fault,
    input  wire logic       batt_discharge_overcurrent_fault,
    input  wire logic       batt_charge_overcurrent_fault,
    input  wire logic       batt_charge_overvolt_fault,
    input  wire logic       thermal_shutdown_flag,
    output logic            sys_reset_n,
    output logic            shipment_request
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic {RST_IDLE, RST_HOLD} rst_state_e;

    function automatic logic [16:0] wdog_limit(input logic [1:0] sel);
        case (sel)
            2'b00:   wdog_limit = 17'(WDOG_P0_MS);
            2'b01:   wdog_limit = 17'(WDOG_P1_MS);
            2'b10:   wdog_limit = 17'(WDOG_P2_MS);
            default: wdog_limit = 17'(WDOG_P3_MS);
        endcase
    endfunction

    logic [7:0]  setting_reg;
    logic [7:0]  fault_reg;
    logic [7:0]  fault_next;
    logic [16:0] wdog_count_reg;
    logic [13:0] press_count_reg;
    logic [10:0] hold_count_reg;
    logic        press_reg;
    logic        supply_reg;
    logic        wdog_fire;
    rst_state_e  rst_state_reg;
    logic        tick;

    ms_tick_divider #(.DIVIDE(TICK_DIV)) ms_tick_divider_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    wire wr_setting    = reg_wr && (reg_addr == SUPERVISOR_SETTING_ADDR);
    wire wr_fault      = reg_wr && (reg_addr == FAULT_FLAGS_ADDR);
    wire wdog_service  = wr_setting && reg_wdata[WDOG_SERVICE_BIT];
    wire wdog_enable   = setting_reg[WDOG_ENABLE_BIT];
    wire [16:0] wdog_lim = wdog_limit(setting_reg[WDOG_PERIOD_LSB +: 2]);
    wire press_raw     = !manual_reset_input_n;
    wire supply_lost   = supply_reg && !bus_supply_input;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            setting_reg <= SETTING_RESET;
        end else if (wr_setting) begin
            setting_reg <= reg_wdata & SETTING_WRITE_MASK;
        end
    end

    // The counter restarts on service or when disabled, so enabling always gives a full period.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_count_reg <= 17'h0;
        end else if (!wdog_enable || wdog_service || wdog_fire) begin
            wdog_count_reg <= 17'h0;
        end else if (tick) begin
            wdog_count_reg <= wdog_count_reg + 17'h1;
        end
    end

    assign wdog_fire = wdog_enable && tick && (wdog_count_reg + 17'h1 >= wdog_lim);

    ////////////////////////////////////////////////////////////////////////////
    wire [7:0] fault_events = {batt_undervolt_fault, batt_discharge_overcurrent_fault,
                               batt_charge_overcurrent_fault, batt_charge_overvolt_fault,
                               1'b0, wdog_fire, 1'b0, thermal_shutdown_flag};
    wire [7:0] fault_clear  = wr_fault ? reg_wdata : 8'h00;

    // Events win over a simultaneous write-one clear so nothing is lost.
    always_comb begin
        fault_next = fault_reg & ~fault_clear;
        if (supply_lost) begin
            fault_next = FAULT_RESET;
        end
        fault_next = (fault_next | fault_events) & FAULT_IMPL_MASK;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_reg  <= FAULT_RESET;
            supply_reg <= 1'b0;
        end else begin
            fault_reg  <= fault_next;
            supply_reg <= bus_supply_input;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Press counter; deglitched status after the short time, shipment after the long one.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            press_count_reg  <= 14'h0;
            press_reg        <= 1'b0;
            shipment_request <= 1'b0;
        end else if (!press_raw) begin
            press_count_reg <= 14'h0;
            press_reg       <= 1'b0;
        end else if (tick) begin
            if (press_count_reg != 14'(SHIP_PRESS_MS)) begin
                press_count_reg <= press_count_reg + 14'h1;
            end
            if (press_count_reg + 14'h1 >= 14'(DEGLITCH_MS)) begin
                press_reg <= 1'b1;
            end
            if (press_count_reg + 14'h1 == 14'(SHIP_PRESS_MS) && setting_reg[SHIP_ENABLE_BIT]) begin
                shipment_request <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    wire monitor_fail = (setting_reg[BUCK_RST_BIT] && !buck_good_status)
                      || (setting_reg[BUCKBOOST_RST_BIT] && !buckboost_good_status);
    wire rst_cause    = monitor_fail || wdog_fire;
    wire [10:0] hold_lim = setting_reg[RESET_TIME_BIT] ? 11'(RESET_LONG_MS) : 11'(RESET_SHORT_MS);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_state_reg  <= RST_IDLE;
            hold_count_reg <= 11'h0;
        end else begin
            case (rst_state_reg)
                RST_IDLE: begin
                    hold_count_reg <= 11'h0;
                    if (rst_cause) begin
                        rst_state_reg <= RST_HOLD;
                    end
                end
                RST_HOLD: begin
                    // A fresh cause restarts the hold, so reset always lasts a full period after the last one.
                    if (rst_cause) begin
                        hold_count_reg <= 11'h0;
                    end else if (tick) begin
                        if (hold_count_reg + 11'h1 >= hold_lim) begin
                            rst_state_reg <= RST_IDLE;
                        end
                        hold_count_reg <= hold_count_reg + 11'h1;
                    end
                end
                default: rst_state_reg <= RST_IDLE;
            endcase
        end
    end

    assign sys_reset_n = (rst_state_reg == RST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    wire [7:0] status_word = {2'b00, press_reg, charge_done_status, supply_in_range_status,
                              battery_above_weak_status, buckboost_good_status,
                              buck_good_status};
    wire [7:0] read_mux = (reg_addr == SUPERVISOR_SETTING_ADDR) ? setting_reg :
                          (reg_addr == FAULT_FLAGS_ADDR)        ? fault_reg   :
                          (reg_addr == POWER_GOOD_STATE_ADDR)   ? status_word : 8'h00;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= read_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_service_self_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wdog_service |=> (setting_reg[WDOG_SERVICE_BIT] == 1'b0) && (wdog_count_reg == 17'h0))
        else $error("service did not restart watchdog");
    chk_wdog_disabled_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wdog_enable |-> !wdog_fire)
        else $error("watchdog fired while disabled");
    chk_wdog_fault_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wdog_fire |=> fault_reg[FAULT_WDOG_BIT])
        else $error("watchdog expiry not latched");
    chk_fault_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fault_reg[FAULT_BATT_UNDERVOLT_FAULT_BIT] && !wr_fault && !supply_lost) |=> fault_reg[FAULT_BATT_UNDERVOLT_FAULT_BIT])
        else $error("fault flag dropped without clear");
    chk_fault_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_fault && reg_wdata[FAULT_THERMAL_BIT] && !thermal_shutdown_flag) |=> !fault_reg[FAULT_THERMAL_BIT])
        else $error("write one did not clear fault");
    chk_thermal_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        thermal_shutdown_flag |=> fault_reg[FAULT_THERMAL_BIT] && !fault_reg[1] && !fault_reg[3])
        else $error("thermal fault not latched");
    chk_reset_on_fail: assert property (@(posedge ref_clk) disable iff (!rst_n)
        monitor_fail |=> !sys_reset_n)
        else $error("reset not asserted on monitor fail");
    chk_ship_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!setting_reg[SHIP_ENABLE_BIT] && !shipment_request) |=> !shipment_request)
        else $error("shipment entered while blocked");
    chk_buck_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == POWER_GOOD_STATE_ADDR) |=> reg_rdata[0] == $past(buck_good_status))
        else $error("buck status read wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Period, hold and press checks count ticks, so they still hold at a short simulation divide.
    chk_wdog_period_p0: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (setting_reg[WDOG_PERIOD_LSB +: 2] == 2'b00) |-> (wdog_lim == 17'(WDOG_P0_MS)))
        else $error("watchdog period code 0 wrong");
    chk_wdog_period_p1: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (setting_reg[WDOG_PERIOD_LSB +: 2] == 2'b01) |-> (wdog_lim == 17'(WDOG_P1_MS)))
        else $error("watchdog period code 1 wrong");
    chk_wdog_period_p2: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (setting_reg[WDOG_PERIOD_LSB +: 2] == 2'b10) |-> (wdog_lim == 17'(WDOG_P2_MS)))
        else $error("watchdog period code 2 wrong");
    chk_wdog_period_p3: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (setting_reg[WDOG_PERIOD_LSB +: 2] == 2'b11) |-> (wdog_lim == 17'(WDOG_P3_MS)))
        else $error("watchdog period code 3 wrong");
    chk_wdog_restart_expiry: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wdog_fire |=> (wdog_count_reg == 17'h0))
        else $error("watchdog did not restart after expiry");
    chk_wdog_idle_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wdog_enable |=> (wdog_count_reg == 17'h0))
        else $error("watchdog counted while disabled");
    chk_reset_on_wdog: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wdog_fire |=> !sys_reset_n)
        else $error("reset not asserted on watchdog expiry");
    chk_reset_stays_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!sys_reset_n && rst_cause) |=> !sys_reset_n)
        else $error("reset released while cause present");
    chk_reset_hold_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(sys_reset_n) |-> (hold_count_reg >= hold_lim))
        else $error("reset released before hold time");
    chk_monitor_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!setting_reg[BUCK_RST_BIT] && !setting_reg[BUCKBOOST_RST_BIT] && !wdog_fire && sys_reset_n)
        |=> sys_reset_n)
        else $error("disabled monitor asserted reset");
    chk_press_status_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !press_raw |=> !press_reg)
        else $error("press status kept after release");
    chk_press_deglitch_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(press_reg) |-> (press_count_reg == 14'(DEGLITCH_MS)))
        else $error("press status at wrong time");
    chk_ship_press_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(shipment_request) |-> (press_count_reg == 14'(SHIP_PRESS_MS)))
        else $error("shipment entered at wrong time");
    chk_ship_request_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        shipment_request |=> shipment_request)
        else $error("shipment request dropped");
    chk_fault_supply_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (supply_lost && !batt_undervolt_fault) |=> !fault_reg[FAULT_BATT_UNDERVOLT_FAULT_BIT])
        else $error("supply cycle did not clear fault");
    chk_undervolt_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        batt_undervolt_fault |=> fault_reg[FAULT_BATT_UNDERVOLT_FAULT_BIT])
        else $error("undervoltage fault not latched");
    chk_discharge_oc_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        batt_discharge_overcurrent_fault |=> fault_reg[6])
        else $error("discharge overcurrent not latched");
    chk_charge_oc_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        batt_charge_overcurrent_fault |=> fault_reg[5])
        else $error("charge overcurrent not latched");
    chk_charge_ov_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        batt_charge_overvolt_fault |=> fault_reg[4])
        else $error("charge overvoltage not latched");
    chk_status_read_live: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == POWER_GOOD_STATE_ADDR) |=> reg_rdata[4:1] == $past({charge_done_status,
            supply_in_range_status, battery_above_weak_status, buckboost_good_status}))
        else $error("live status read wrong");
    chk_status_press_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == POWER_GOOD_STATE_ADDR) |=> (reg_rdata[7:5] == {2'b00, $past(press_reg)}))
        else $error("press status read wrong");
endmodule

// *** verif/host_reset_monitor.sv ***
// Host-side model that watches the system reset line and counts reset entries.
`timescale 1ns/10ps
module host_reset_monitor (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic sys_reset_n,
    output int        entries
);
    ////////////////////////////////////////////////////////////////////////////
    // The host only observes reset here; watchdog servicing is issued by the bench.
    logic held_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            held_reg <= 1'b1;
            entries  <= 0;
        end else begin
            held_reg <= sys_reset_n;
            if (held_reg && !sys_reset_n) begin
                entries <= entries + 1;
            end
        end
    end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the supervisor, watchdog and fault register block.
`timescale 1ns/10ps
module tb_top import supervisor_pkg::*;;
    logic       ref_clk, rst_n, reg_wr, reg_rd, mr_n, supply, sys_reset_n, shipment_request;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [4:0] live, flt;
    int         n_errors, num_checks, pulses, p0;
    int         cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    supervisor_watchdog_fault_status #(.TICK_DIV(2)) supervisor_watchdog_fault_status_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .manual_reset_input_n(mr_n), .bus_supply_input(supply),
        .supply_in_range_status(live[3]), .charge_done_status(live[4]), .battery_above_weak_status(live[2]),
        .buckboost_good_status(live[1]), .buck_good_status(live[0]), .batt_undervolt_fault(flt[4]),
        .batt_discharge_overcurrent_fault(flt[3]), .batt_charge_overcurrent_fault(flt[2]),
        .batt_charge_overvolt_fault(flt[1]), .thermal_shutdown_flag(flt[0]),
        .sys_reset_n(sys_reset_n), .shipment_request(shipment_request));
    host_reset_monitor host_reset_monitor_inst (.ref_clk(ref_clk), .rst_n(rst_n), .sys_reset_n(sys_reset_n),
        .entries(pulses));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // The longest test waits on the watchdog period, so the ceiling sits about 15000 cycles above the total run of about 75000.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_errors = n_errors + 1;
            conclude();
        end
    end
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic got, input logic exp, input string what);
        cmp_byte({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic hop(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        cmp_byte(reg_rdata, e, what);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        mr_n = 1'b1; supply = 1'b1; live = 5'h1F; flt = 5'h00; n_errors = 0; num_checks = 0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(SUPERVISOR_SETTING_ADDR, 8'h80, "setting after reset");
        rd(FAULT_FLAGS_ADDR, 8'h00, "faults after reset");
        rd(8'h30, 8'h00, "unmapped read");
        wr(SUPERVISOR_SETTING_ADDR, 8'hFF);
        rd(SUPERVISOR_SETTING_ADDR, 8'hFE, "setting write all");
        wr(SUPERVISOR_SETTING_ADDR, 8'h08);
        rd(SUPERVISOR_SETTING_ADDR, 8'h08, "period code one");
        wr(SUPERVISOR_SETTING_ADDR, 8'h10);
        rd(SUPERVISOR_SETTING_ADDR, 8'h10, "period code two");
        wr(SUPERVISOR_SETTING_ADDR, 8'h00);
        wr(POWER_GOOD_STATE_ADDR, 8'h00);
        rd(POWER_GOOD_STATE_ADDR, 8'h1F, "status ignores write");
        $display("test register access done");
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            live <= 5'(1 << i);
            rd(POWER_GOOD_STATE_ADDR, 8'(1 << i), "live status bit");
        end
        @(posedge ref_clk);
        live <= 5'h1F;
        mr_n <= 1'b0;
        hop(110);
        rd(POWER_GOOD_STATE_ADDR, 8'h3F, "press status");
        @(posedge ref_clk);
        mr_n <= 1'b1;
        rd(POWER_GOOD_STATE_ADDR, 8'h1F, "press released");
        $display("test status done");
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            flt <= 5'(1 << i);
            @(posedge ref_clk);
            flt <= 5'h00;
            rd(FAULT_FLAGS_ADDR, (i == 0) ? 8'h01 : 8'(8'h08 << i), "fault latched");
            wr(FAULT_FLAGS_ADDR, (i == 0) ? 8'h01 : 8'(8'h08 << i));
            rd(FAULT_FLAGS_ADDR, 8'h00, "fault cleared");
        end
        @(posedge ref_clk);
        flt <= 5'h1F;
        @(posedge ref_clk);
        flt <= 5'h00;
        wr(FAULT_FLAGS_ADDR, 8'h0A);
        rd(FAULT_FLAGS_ADDR, 8'hF1, "reserved write keeps faults");
        @(posedge ref_clk);
        supply <= 1'b0;
        @(posedge ref_clk);
        supply <= 1'b1;
        rd(FAULT_FLAGS_ADDR, 8'h00, "supply cycle clears");
        $display("test faults done");
        wr(SUPERVISOR_SETTING_ADDR, 8'h80);
        live <= 5'h1E;
        hop(3);
        cmp_pin(sys_reset_n, 1'b0, "buck monitor reset");
        @(posedge ref_clk);
        live <= 5'h1D;
        hop(370);
        cmp_pin(sys_reset_n, 1'b0, "short hold running");
        hop(40);
        cmp_pin(sys_reset_n, 1'b1, "short hold over, buck-boost ignored");
        wr(SUPERVISOR_SETTING_ADDR, 8'h60);
        hop(3);
        cmp_pin(sys_reset_n, 1'b0, "buck-boost monitor reset");
        @(posedge ref_clk);
        live <= 5'h1E;
        hop(3150);
        cmp_pin(sys_reset_n, 1'b0, "long hold running");
        hop(80);
        cmp_pin(sys_reset_n, 1'b1, "long hold over, buck ignored");
        @(posedge ref_clk);
        live <= 5'h1F;
        wr(SUPERVISOR_SETTING_ADDR, 8'h00);
        $display("test monitors done");
        @(posedge ref_clk);
        mr_n <= 1'b0;
        hop(26000);
        cmp_pin(shipment_request, 1'b0, "shipment blocked");
        rd(FAULT_FLAGS_ADDR, 8'h00, "watchdog disabled");
        @(posedge ref_clk);
        mr_n <= 1'b1;
        wr(SUPERVISOR_SETTING_ADDR, 8'h06);
        mr_n <= 1'b0;
        p0 = pulses;
        hop(20000);
        wr(SUPERVISOR_SETTING_ADDR, 8'h07);
        rd(SUPERVISOR_SETTING_ADDR, 8'h06, "service bit self clears");
        hop(2900);
        cmp_pin(shipment_request, 1'b0, "shipment not yet");
        hop(1300);
        cmp_pin(shipment_request, 1'b1, "shipment entered");
        hop(18000);
        rd(FAULT_FLAGS_ADDR, 8'h00, "serviced watchdog quiet");
        hop(3000);
        rd(FAULT_FLAGS_ADDR, 8'h04, "watchdog expired");
        cmp_byte(8'(pulses - p0), 8'h01, "watchdog reset entry");
        wr(FAULT_FLAGS_ADDR, 8'h04);
        rd(FAULT_FLAGS_ADDR, 8'h00, "watchdog flag cleared");
        $display("test watchdog and shipment done");
        @(posedge ref_clk);
        mr_n  <= 1'b1;
        rst_n <= 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        hop(1);
        cmp_pin(shipment_request, 1'b0, "reset clears shipment");
        cmp_pin(sys_reset_n, 1'b1, "reset output idle after reset");
        rd(SUPERVISOR_SETTING_ADDR, 8'h80, "setting after second reset");
        rd(FAULT_FLAGS_ADDR, 8'h00, "faults after second reset");
        $display("test second reset done");
        conclude();
    end
endmodule
